// ===== rtl/iatm_pkg.sv
/*
  Package for the integrator and time measure block: register map,
  field positions, reset values and the packed control carriers.
  Assumes a 32-bit APB register bus with byte addresses.
*/
package iatm_pkg;

  // ****************************************************************
  // register map (byte addresses)
  // ****************************************************************
  localparam logic [7:0] CTRL_OFFSET = 8'h00;
  localparam logic [7:0] PARAM_OFFSET = 8'h04;
  localparam logic [7:0] DATA_OFFSET = 8'h08;
  localparam logic [7:0] TIME_OFFSET = 8'h0C;
  localparam logic [7:0] STATUS_OFFSET = 8'h10;

  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] PARAM_RESET = 32'h0000_0001;

  // ****************************************************************
  // field layout
  // ****************************************************************
  localparam int CTRL_WIDTH = 8;
  localparam int RATIO_WIDTH = 8;
  localparam int SHIFT_WIDTH = 5;
  localparam int PARAM_WIDTH = RATIO_WIDTH + SHIFT_WIDTH;
  localparam int STATUS_WIDTH = 3;
  localparam int ST_INT_OVF = 0;
  localparam int ST_TIME_OVF = 1;
  localparam int ST_DATA_NEW = 2;

  localparam logic [RATIO_WIDTH-1:0] RATIO_MIN = 8'h01;
  localparam logic [RATIO_WIDTH-1:0] RATIO_MAX = 8'h80;
  localparam logic [SHIFT_WIDTH-1:0] SHIFT_MAX = 5'h10;

  // ****************************************************************
  // accumulator limits (33-bit signed view)
  // ****************************************************************
  localparam logic signed [32:0] ACC_MAX = 33'sh0_7FFF_FFFF;
  localparam logic signed [32:0] ACC_MIN = 33'sh1_8000_0000;
  localparam logic [15:0] TIME_MAX = 16'hFFFF;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic multi_filter_enable;
    logic filter_enable;
    logic demodulation_enable;
    logic data_width_select;
    logic timer_mode_select;
    logic strobe_select;
    logic integration_mode_select;
    logic integrator_enable;
  } iatm_ctrl_s;

  typedef struct packed {
    logic [SHIFT_WIDTH-1:0] shift_count;
    logic [RATIO_WIDTH-1:0] integrator_sample_count;
  } iatm_param_s;

endpackage

// ===== rtl/iatm_top.sv
/*
  Integrator stage and time measure unit of one filter module, with an
  APB register slave. Assumes the sinc filter output arrives as a
  signed word with a one-cycle valid on pclk; strobes and the
  modulator clock are asynchronous pins.
*/
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - 32-bit signed accumulator adds each sample
// - mode bit: 1 strobe timing, 0 count
// - enable low: cleared accumulator, input passes through
// - strobe edge stores sum, clears accumulator
// - count mode sums 1 to 128 samples
// - one sample per sinc output word
// - filter enable rise starts new integration
// - multi-filter enable rise restarts accumulation together
// - count mode flags overflow at limit
// - strobe mode flags overflow past limit
// - overflow clears accumulator, integration continues
// - 16-bit mode selects slice by shift
// - shift N gives the sign bit above bits N+14 to N
// - 16-bit slice keeps true sign
// - raw bits need sinc1, ratio 1, enabled
// - demodulation after phase calibration when enabled
// - time counter on modulator or system clock
// - time counter range is 16 bits
// - mode 1 counts modulator clocks between strobes
// - strobe edge latches count, clears counter
// - mode 0 counts pclk, clears on data
// - wrap sets time overflow, read clears
module iatm_top #(
  parameter int SAMPLE_WIDTH = 26
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic signed [SAMPLE_WIDTH-1:0] sinc_data,
  input wire logic sinc_valid,
  input wire logic phase_cal_done,
  input wire logic demod_polarity,
  input wire logic [1:0] sample_hold_strobe,
  input wire logic modulator_clock,
  output logic filter_enable,
  output logic multi_filter_enable,
  output logic data_ready,
  output logic integrator_overflow_flag,
  output logic time_overflow_flag
);

  // ****************************************************************
  // registers
  // ****************************************************************
  iatm_pkg::iatm_ctrl_s ctrl_reg;
  iatm_pkg::iatm_param_s param_reg;
  logic [31:0] data_reg;
  logic [15:0] time_reg;
  logic [15:0] tcnt_reg;
  logic [31:0] acc_reg;
  logic [iatm_pkg::RATIO_WIDTH-1:0] cnt_reg;
  logic [iatm_pkg::STATUS_WIDTH-1:0] status_reg;
  logic [iatm_pkg::STATUS_WIDTH-1:0] rd_clear_reg;
  logic [31:0] prdata_reg;
  logic data_ready_reg;
  logic fen_q;
  logic mfe_q;

  // ****************************************************************
  // apb slave
  // ****************************************************************
  logic setup_ph;
  logic access_ph;
  logic mapped;
  logic [31:0] rd_value;

  assign setup_ph = psel && !penable;
  assign access_ph = psel && penable;
  assign mapped = (paddr == iatm_pkg::CTRL_OFFSET) || (paddr == iatm_pkg::PARAM_OFFSET) ||
                  (paddr == iatm_pkg::DATA_OFFSET) || (paddr == iatm_pkg::TIME_OFFSET) ||
                  (paddr == iatm_pkg::STATUS_OFFSET);
  assign pready = 1'b1;
  assign pslverr = access_ph && !mapped;
  assign prdata = prdata_reg;

  always_comb begin
    rd_value = 32'h0000_0000;
    unique case (paddr)
      iatm_pkg::CTRL_OFFSET: rd_value = {24'h00_0000, ctrl_reg};
      iatm_pkg::PARAM_OFFSET: rd_value = {19'h0_0000, param_reg};
      iatm_pkg::DATA_OFFSET: rd_value = data_reg;
      iatm_pkg::TIME_OFFSET: rd_value = {16'h0000, time_reg};
      iatm_pkg::STATUS_OFFSET: rd_value = {29'h0000_0000, status_reg};
      default: rd_value = 32'h0000_0000;
    endcase
  end

  // read data and status snapshot taken in the setup cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= 32'h0000_0000;
      rd_clear_reg <= 3'h0;
    end else if (setup_ph) begin
      prdata_reg <= rd_value;
      rd_clear_reg <= (!pwrite && paddr == iatm_pkg::STATUS_OFFSET) ? status_reg : 3'h0;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ctrl_reg <= iatm_pkg::CTRL_RESET[iatm_pkg::CTRL_WIDTH-1:0];
      param_reg <= iatm_pkg::PARAM_RESET[iatm_pkg::PARAM_WIDTH-1:0];
    end else if (access_ph && pwrite) begin
      if (paddr == iatm_pkg::CTRL_OFFSET) begin
        ctrl_reg <= pwdata[iatm_pkg::CTRL_WIDTH-1:0];
      end
      if (paddr == iatm_pkg::PARAM_OFFSET) begin
        param_reg <= pwdata[iatm_pkg::PARAM_WIDTH-1:0];
      end
    end
  end

  assign filter_enable = ctrl_reg.filter_enable;
  assign multi_filter_enable = ctrl_reg.multi_filter_enable;

  // ****************************************************************
  // pin synchronisers and edge detect
  // ****************************************************************
  logic [2:0] pin_in;
  logic [2:0] sy1_reg;
  logic [2:0] sy2_reg;
  logic [2:0] sy3_reg;
  logic [2:0] lvl_reg;
  logic [2:0] rise;

  assign pin_in = {modulator_clock, sample_hold_strobe};

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          sy1_reg[gi] <= 1'b0;
          sy2_reg[gi] <= 1'b0;
          sy3_reg[gi] <= 1'b0;
          lvl_reg[gi] <= 1'b0;
        end else begin
          sy1_reg[gi] <= pin_in[gi];
          sy2_reg[gi] <= sy1_reg[gi];
          sy3_reg[gi] <= sy2_reg[gi];
          if (sy2_reg[gi] == sy3_reg[gi]) begin
            lvl_reg[gi] <= sy3_reg[gi];
          end
        end
      end
      assign rise[gi] = (sy2_reg[gi] == sy3_reg[gi]) && sy3_reg[gi] && !lvl_reg[gi];
      property p_sync_edge;
        @(posedge pclk) disable iff (!presetn)
        rise[gi] |=> lvl_reg[gi];
      endproperty
      a_sync_edge: assert property (p_sync_edge) else $error("edge without settled level");
    end
  endgenerate
  logic sh_edge;
  logic mod_edge;
  assign sh_edge = ctrl_reg.strobe_select ? rise[1] : rise[0];
  assign mod_edge = rise[2];

  // ****************************************************************
  // integrator
  // ****************************************************************
  logic restart;
  logic signed [31:0] sample_ext;
  logic signed [31:0] sample_dm;
  logic signed [32:0] sum33;
  logic ovf_now;
  logic [iatm_pkg::RATIO_WIDTH-1:0] ratio;
  logic last_sample;
  logic load;
  logic [31:0] load_value;
  logic [31:0] fmt_value;
  logic [iatm_pkg::SHIFT_WIDTH-1:0] shamt;
  logic signed [31:0] shifted;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fen_q <= 1'b0;
      mfe_q <= 1'b0;
    end else begin
      fen_q <= ctrl_reg.filter_enable;
      mfe_q <= ctrl_reg.multi_filter_enable;
    end
  end

  assign restart = (ctrl_reg.filter_enable && !fen_q) || (ctrl_reg.multi_filter_enable && !mfe_q);
  assign sample_ext = 32'(sinc_data);
  assign sample_dm = (ctrl_reg.demodulation_enable && phase_cal_done && demod_polarity) ?
                     -sample_ext : sample_ext;
  assign sum33 = {acc_reg[31], acc_reg} + {sample_dm[31], sample_dm};

  always_comb begin
    if (ctrl_reg.integration_mode_select) begin
      ovf_now = (sum33 > iatm_pkg::ACC_MAX) || (sum33 < iatm_pkg::ACC_MIN);
    end else begin
      ovf_now = (sum33 >= iatm_pkg::ACC_MAX) || (sum33 <= iatm_pkg::ACC_MIN);
    end
  end

  assign ratio =
    (param_reg.integrator_sample_count < iatm_pkg::RATIO_MIN) ? iatm_pkg::RATIO_MIN :
    (param_reg.integrator_sample_count > iatm_pkg::RATIO_MAX) ? iatm_pkg::RATIO_MAX :
    param_reg.integrator_sample_count;
  assign last_sample = (cnt_reg + 8'h01) >= ratio;
  // result events: bypass, strobe dump, count dump
  always_comb begin
    load = 1'b0;
    load_value = 32'h0000_0000;
    if (!ctrl_reg.integrator_enable) begin
      load = sinc_valid;
      load_value = sample_dm;
    end else if (ctrl_reg.integration_mode_select) begin
      load = sh_edge;
      load_value = acc_reg;
    end else if (!restart) begin
      load = sinc_valid && last_sample;
      load_value = sum33[31:0];
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 8'h00;
    end else if (!ctrl_reg.integrator_enable) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 8'h00;
    end else if (restart) begin
      acc_reg <= 32'h0000_0000;
      cnt_reg <= 8'h00;
    end else if (ctrl_reg.integration_mode_select) begin
      cnt_reg <= 8'h00;
      if (sh_edge) begin
        acc_reg <= sinc_valid ? sample_dm : 32'h0000_0000;
      end else if (sinc_valid) begin
        acc_reg <= ovf_now ? 32'h0000_0000 : sum33[31:0];
      end
    end else if (sinc_valid) begin
      if (last_sample || ovf_now) begin
        acc_reg <= 32'h0000_0000;
      end else begin
        acc_reg <= sum33[31:0];
      end
      cnt_reg <= last_sample ? 8'h00 : cnt_reg + 8'h01;
    end
  end

  // ****************************************************************
  // 16-bit data shifting
  // ****************************************************************
  assign shamt = (param_reg.shift_count > iatm_pkg::SHIFT_MAX) ?
                 iatm_pkg::SHIFT_MAX : param_reg.shift_count;
  assign shifted = $signed(load_value) >>> shamt;

  always_comb begin
    if (ctrl_reg.data_width_select) begin
      fmt_value = load_value;
    end else begin
      fmt_value = {{17{load_value[31]}}, shifted[14:0]};
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= 32'h0000_0000;
      data_ready_reg <= 1'b0;
    end else begin
      data_ready_reg <= load;
      if (load) begin
        data_reg <= fmt_value;
      end
    end
  end
  assign data_ready = data_ready_reg;

  // ****************************************************************
  // time measure
  // ****************************************************************
  logic tick;
  logic tclr;
  logic twrap;
  assign tick = ctrl_reg.timer_mode_select ? mod_edge : 1'b1;
  assign tclr = !ctrl_reg.timer_mode_select && load;
  assign twrap = tick && !sh_edge && !tclr && (tcnt_reg == iatm_pkg::TIME_MAX);
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tcnt_reg <= 16'h0000;
      time_reg <= 16'h0000;
    end else if (sh_edge) begin
      time_reg <= tcnt_reg;
      tcnt_reg <= 16'h0000;
    end else if (tclr) begin
      tcnt_reg <= 16'h0000;
    end else if (tick) begin
      tcnt_reg <= tcnt_reg + 16'h0001;
    end
  end

  // ****************************************************************
  // status flags, set wins over read clear
  // ****************************************************************
  logic [iatm_pkg::STATUS_WIDTH-1:0] st_set;
  logic [iatm_pkg::STATUS_WIDTH-1:0] st_clr;
  logic int_ovf_set;
  assign int_ovf_set = ctrl_reg.integrator_enable && !restart && sinc_valid && ovf_now &&
                       !(ctrl_reg.integration_mode_select && sh_edge);
  assign st_set = {load, twrap, int_ovf_set};
  assign st_clr = (access_ph && !pwrite && paddr == iatm_pkg::STATUS_OFFSET) ?
                  rd_clear_reg : 3'h0;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      status_reg <= 3'h0;
    end else begin
      status_reg <= (status_reg & ~st_clr) | st_set;
    end
  end

  assign integrator_overflow_flag = status_reg[iatm_pkg::ST_INT_OVF];
  assign time_overflow_flag = status_reg[iatm_pkg::ST_TIME_OVF];

  // ****************************************************************
  // checks
  // ****************************************************************
  property p_disabled_clear;
    @(posedge pclk) disable iff (!presetn)
    !ctrl_reg.integrator_enable |=> acc_reg == 32'h0000_0000;
  endproperty
  a_disabled_clear: assert property (p_disabled_clear) else $error("acc not held clear");
  property p_bypass;
    @(posedge pclk) disable iff (!presetn)
    (!ctrl_reg.integrator_enable && sinc_valid && ctrl_reg.data_width_select)
      |=> data_ready && data_reg == $past(sample_dm);
  endproperty
  a_bypass: assert property (p_bypass) else $error("bypass value wrong");
  property p_sh_dump;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.integrator_enable && ctrl_reg.integration_mode_select && !restart && sh_edge &&
     ctrl_reg.data_width_select) |=> data_ready && data_reg == $past(acc_reg);
  endproperty
  a_sh_dump: assert property (p_sh_dump) else $error("strobe dump wrong");
  property p_osr_dump;
    @(posedge pclk) disable iff (!presetn)
    (ctrl_reg.integrator_enable && !ctrl_reg.integration_mode_select && !restart &&
     sinc_valid && (cnt_reg + 8'h01) >= ratio) |=> cnt_reg == 8'h00 && acc_reg == 32'h0 &&
     data_ready;
  endproperty
  a_osr_dump: assert property (p_osr_dump) else $error("count dump wrong");
  property p_restart;
    @(posedge pclk) disable iff (!presetn)
    $rose(ctrl_reg.multi_filter_enable) ##0 ctrl_reg.integrator_enable
      |=> acc_reg == 32'h0 && cnt_reg == 8'h00;
  endproperty
  a_restart: assert property (p_restart) else $error("restart missed");
  property p_ovf;
    @(posedge pclk) disable iff (!presetn)
    int_ovf_set |=> integrator_overflow_flag && acc_reg == 32'h0;
  endproperty
  a_ovf: assert property (p_ovf) else $error("overflow not handled");
  property p_sign;
    @(posedge pclk) disable iff (!presetn)
    (load && !ctrl_reg.data_width_select) |=> data_reg[15] == $past(load_value[31]);
  endproperty
  a_sign: assert property (p_sign) else $error("16-bit sign lost");
  property p_time_latch;
    @(posedge pclk) disable iff (!presetn)
    sh_edge |=> time_reg == $past(tcnt_reg) && tcnt_reg == 16'h0000;
  endproperty
  a_time_latch: assert property (p_time_latch) else $error("time latch wrong");
  property p_time_wrap;
    @(posedge pclk) disable iff (!presetn)
    twrap |=> tcnt_reg == 16'h0000 ##1 time_overflow_flag;
  endproperty
  a_time_wrap: assert property (p_time_wrap) else $error("wrap flag missing");
endmodule

`default_nettype wire

// ===== verification/iatm_mod_model.sv
/*
  Far side model: modulator clock and the two sample-and-hold pins.
  Assumes the bench calls one task at a time.
*/
`timescale 1ns/1ps
`default_nettype none

module iatm_mod_model (
  output logic modulator_clock,
  output logic [1:0] sample_hold_strobe
);
  // ****************************************************************
  // link clock, still outside bursts
  // ****************************************************************
  initial begin
    modulator_clock = 1'b0;
    sample_hold_strobe = 2'h0;
  end

  task automatic run_clock(input int n);
    #7;
    repeat (n) begin
      modulator_clock = 1'b1;
      #100;
      modulator_clock = 1'b0;
      #100;
    end
  endtask

  // ****************************************************************
  // strobes, held long enough for the synchroniser
  // ****************************************************************
  task automatic pulse_strobe(input int idx);
    sample_hold_strobe[idx] = 1'b1;
    #500;
    sample_hold_strobe[idx] = 1'b0;
    #500;
  endtask
endmodule

`default_nettype wire

// ===== verification/testbench.sv
/*
  Self-checking bench for the integrator and time measure block.
  Assumes the design package is compiled first.
*/
`timescale 1ns/1ps
`default_nettype none

module testbench;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [7:0] ratio;
    logic [4:0] shift;
    logic signed [25:0] sample;
    logic [7:0] count;
    logic [31:0] exp_data;
  } iatm_row_s;

  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  logic signed [25:0] sinc_data;
  logic sinc_valid, phase_cal_done, demod_polarity, modulator_clock;
  logic [1:0] sample_hold_strobe;
  logic filter_enable, multi_filter_enable, data_ready;
  logic integrator_overflow_flag, time_overflow_flag, seen, err;
  int failures = 0;
  int tests_run = 0;
  int cycles = 0;

  iatm_row_s rows [0:10] = '{
    '{8'h51, 8'h01, 5'h00, 26'sh5, 8'h01, 32'h0000_0005},
    '{8'h51, 8'h03, 5'h00, -26'sh7, 8'h03, 32'hFFFF_FFEB},
    '{8'h51, 8'h80, 5'h00, 26'sh3E8, 8'h80, 32'h0001_F400},
    '{8'h51, 8'hC8, 5'h00, 26'sh1, 8'h80, 32'h0000_0080},
    '{8'h51, 8'h00, 5'h00, 26'sh9, 8'h01, 32'h0000_0009},
    '{8'h41, 8'h04, 5'h09, 26'sh123456, 8'h04, 32'h0000_2468},
    '{8'h41, 8'h02, 5'h0E, -26'sh100000, 8'h02, 32'hFFFF_FF80},
    '{8'h41, 8'h01, 5'h01, 26'sh3FFFF, 8'h01, 32'h0000_7FFF},
    '{8'h41, 8'h01, 5'h00, -26'sh3, 8'h01, 32'hFFFF_FFFD},
    '{8'h50, 8'h03, 5'h00, 26'sh4D, 8'h01, 32'h0000_004D},
    '{8'h71, 8'h02, 5'h00, 26'sh6, 8'h02, 32'hFFFF_FFF4}
  };

  iatm_top iatm_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .sinc_data(sinc_data), .sinc_valid(sinc_valid),
    .phase_cal_done(phase_cal_done), .demod_polarity(demod_polarity),
    .sample_hold_strobe(sample_hold_strobe), .modulator_clock(modulator_clock),
    .filter_enable(filter_enable), .multi_filter_enable(multi_filter_enable),
    .data_ready(data_ready), .integrator_overflow_flag(integrator_overflow_flag),
    .time_overflow_flag(time_overflow_flag));

  iatm_mod_model iatm_mod_model_i (.modulator_clock(modulator_clock),
    .sample_hold_strobe(sample_hold_strobe));

  // ****************************************************************
  // clock, timeout, verdict
  // ****************************************************************
  initial begin
    pclk = 1'b0;
    forever #12.5 pclk = ~pclk;
  end

  always @(posedge pclk) begin
    cycles++;
    if (cycles == 90000) begin
      failures++;
      print_verdict();
    end
  end

  task automatic print_verdict();
    if (failures == 0 && tests_run > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // ****************************************************************
  // bus and stream tasks
  // ****************************************************************
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d, rdat, err);
  endtask

  task automatic rd_chk(input logic [7:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0, rdat, err);
    check(rdat, e);
  endtask

  task automatic send(input logic signed [25:0] s, input logic [7:0] n);
    for (int k = 0; k < n; k++) begin
      @(posedge pclk);
      sinc_valid <= 1'b1;
      sinc_data <= s;
    end
    @(posedge pclk);
    sinc_valid <= 1'b0;
  endtask

  task automatic wait_ready();
    seen = 1'b0;
    for (int k = 0; k < 20 && !seen; k++) begin
      @(negedge pclk);
      seen = (data_ready === 1'b1);
    end
    check({31'h0, seen}, 32'h1);
  endtask

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    sinc_data = 26'sh0;
    sinc_valid = 1'b0;
    phase_cal_done = 1'b1;
    demod_polarity = 1'b1;
    repeat (4) @(posedge pclk);
    @(negedge pclk);
    check({pready, filter_enable, multi_filter_enable, data_ready}, 32'h8);
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(iatm_pkg::CTRL_OFFSET, iatm_pkg::CTRL_RESET);
    rd_chk(iatm_pkg::PARAM_OFFSET, iatm_pkg::PARAM_RESET);
    for (int i = 0; i < 11; i++) begin
      wr(iatm_pkg::CTRL_OFFSET, 32'h0);
      wr(iatm_pkg::PARAM_OFFSET, {19'h0, rows[i].shift, rows[i].ratio});
      wr(iatm_pkg::CTRL_OFFSET, {24'h0, rows[i].ctrl});
      send(rows[i].sample, rows[i].count);
      wait_ready();
      rd_chk(iatm_pkg::DATA_OFFSET, rows[i].exp_data);
    end
    // restart by multi enable drops the partial sum
    wr(iatm_pkg::PARAM_OFFSET, 32'h4);
    send(26'sh3, 8'h02);
    wr(iatm_pkg::CTRL_OFFSET, 32'hC1);
    send(26'sh1, 8'h04);
    wait_ready();
    rd_chk(iatm_pkg::DATA_OFFSET, 32'h4);
    check({30'h0, filter_enable, multi_filter_enable}, 32'h3);
    // no negation before phase calibration completes
    phase_cal_done <= 1'b0;
    wr(iatm_pkg::CTRL_OFFSET, 32'h70);
    send(26'sh6, 8'h01);
    wait_ready();
    rd_chk(iatm_pkg::DATA_OFFSET, 32'h6);
    phase_cal_done <= 1'b1;
    // count mode overflow
    wr(iatm_pkg::CTRL_OFFSET, 32'h0);
    wr(iatm_pkg::PARAM_OFFSET, 32'h80);
    wr(iatm_pkg::CTRL_OFFSET, 32'h51);
    send(26'sh1FFFFFF, 8'h80);
    wait_ready();
    rd_chk(iatm_pkg::DATA_OFFSET, 32'h7DFF_FFC1);
    @(negedge pclk);
    check({31'h0, integrator_overflow_flag}, 32'h1);
    apb(1'b0, iatm_pkg::STATUS_OFFSET, 32'h0, rdat, err);
    check(rdat & 32'h1, 32'h1);
    @(negedge pclk);
    check({31'h0, integrator_overflow_flag}, 32'h0);
    // strobe timing and timer mode 1
    wr(iatm_pkg::CTRL_OFFSET, 32'h0);
    wr(iatm_pkg::CTRL_OFFSET, 32'h5F);
    iatm_mod_model_i.pulse_strobe(1);
    iatm_mod_model_i.run_clock(5);
    send(26'shA, 8'h03);
    iatm_mod_model_i.pulse_strobe(0);
    rd_chk(iatm_pkg::DATA_OFFSET, 32'h0);
    iatm_mod_model_i.pulse_strobe(1);
    rd_chk(iatm_pkg::DATA_OFFSET, 32'h1E);
    rd_chk(iatm_pkg::TIME_OFFSET, 32'h5);
    wr(iatm_pkg::TIME_OFFSET, 32'hFFFF);
    rd_chk(iatm_pkg::TIME_OFFSET, 32'h5);
    apb(1'b0, 8'h20, 32'h0, rdat, err);
    check({rdat[30:0], err}, 32'h1);
    // timer mode 0 wrap
    wr(iatm_pkg::CTRL_OFFSET, 32'h57);
    iatm_mod_model_i.pulse_strobe(1);
    repeat (65300) @(posedge pclk);
    @(negedge pclk);
    check({31'h0, time_overflow_flag}, 32'h0);
    for (int k = 0; k < 400 && time_overflow_flag !== 1'b1; k++) @(negedge pclk);
    check({31'h0, time_overflow_flag}, 32'h1);
    apb(1'b0, iatm_pkg::STATUS_OFFSET, 32'h0, rdat, err);
    check(rdat & 32'h2, 32'h2);
    @(negedge pclk);
    check({31'h0, time_overflow_flag}, 32'h0);
    // reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    @(negedge pclk);
    check({pready, filter_enable, multi_filter_enable, data_ready, time_overflow_flag}, 32'h10);
    @(posedge pclk);
    presetn <= 1'b1;
    rd_chk(iatm_pkg::CTRL_OFFSET, iatm_pkg::CTRL_RESET);
    rd_chk(iatm_pkg::PARAM_OFFSET, iatm_pkg::PARAM_RESET);
    print_verdict();
  end
endmodule

`default_nettype wire
